// ### logic/dcs_dma_channels.sv
// Eight-channel DMA configuration, status and transfer engine with APB access
`include "dcs_defs.svh"

module dcs_dma_channels #(
	parameter int NCH = `DCS_NCH, // Channel count
	parameter int NREQ = `DCS_NREQ // Request lines
) (
	input wire logic SYS_CLK, // System clock
	input wire logic RST_N, // Async reset, low
	input wire logic PSEL, // APB select
	input wire logic PENABLE, // APB access phase
	input wire logic PWRITE, // APB direction
	input wire logic [11:0] PADDR, // APB byte address
	input wire logic [31:0] PWDATA, // APB write data
	output logic [31:0] PRDATA, // APB read data
	output logic PREADY, // APB ready
	output logic PSLVERR, // APB error
	input wire logic [NREQ-1:0] REQ_LINES, // Peripheral request lines
	output dcs_pkg::dcs_word_t RAM_ADDR, // DMA RAM address
	output logic RAM_RE, // DMA RAM read
	output logic RAM_WE, // DMA RAM write
	output dcs_pkg::dcs_word_t RAM_WDATA, // DMA RAM write data
	input wire dcs_pkg::dcs_word_t RAM_RDATA, // RAM data, one cycle after read
	output dcs_pkg::dcs_word_t PER_ADDR, // Peripheral register address
	output logic PER_RE, // Peripheral read
	output logic PER_WE, // Peripheral write
	output dcs_pkg::dcs_word_t PER_WDATA, // Peripheral write data
	input wire dcs_pkg::dcs_word_t PER_RDATA, // Peripheral data, one cycle after read
	input wire logic CPU_RAM_WE, // CPU writes DMA RAM
	input wire dcs_pkg::dcs_word_t CPU_RAM_ADDR, // CPU RAM write address
	input wire logic CPU_PER_WE, // CPU writes a peripheral
	input wire dcs_pkg::dcs_word_t CPU_PER_ADDR, // CPU peripheral write address
	output logic IRQ // Level interrupt
);
	import dcs_pkg::*;

	// Per-channel configuration
	logic [NCH-1:0] en_q; // Channel enable
	logic [NCH-1:0] dir_q; // 1: RAM to peripheral
	logic [NCH-1:0] pp_q; // Alternate buffers per block
	logic [NCH-1:0] force_q; // Forced transfer pending
	logic [`DCS_SEL_W-1:0] sel_q [NCH]; // Request select
	dcs_word_t sta_q [NCH]; // Primary start
	dcs_word_t stb_q [NCH]; // Secondary start
	dcs_word_t pad_q [NCH]; // Peripheral address
	logic [`DCS_CNT_W-1:0] cnt_q [NCH]; // Programmed count
	// Per-channel working state
	dcs_word_t ptr_q [NCH]; // Live RAM pointer
	logic [`DCS_CNT_W-1:0] rem_q [NCH]; // Transfers done in block
	logic [NCH-1:0] bsel_q; // Buffer B in use
	logic [NCH-1:0] trig_q; // Request edge pending
	logic [NCH-1:0] prev_q; // Last sampled request
	logic [NCH-1:0] want; // Channel asks for service
	// Shared status
	logic [NCH-1:0] pcol_q; // Peripheral collisions
	logic [NCH-1:0] xcol_q; // RAM collisions
	logic [NCH-1:0] ist_q; // Block-done events
	logic [NCH-1:0] imsk_q; // Interrupt mask
	// Engine
	dcs_xfer_e state_q; // Engine state
	logic [2:0] act_q; // Active channel
	logic act_force_q; // Active move was forced
	logic act_dir_q; // Active direction
	dcs_word_t data_q; // Captured source word
	dcs_word_t ram_addr_q; // RAM address held
	dcs_word_t per_addr_q; // Peripheral address held
	logic [2:0] gnt; // Granted channel
	logic gnt_v; // Any grant
	logic xdone; // Last cycle of a transfer
	// Bus decode
	logic wr_acc; // Write access edge
	logic rd_acc; // Read access edge
	logic rd_setup; // Read setup cycle
	logic glb; // Shared register space
	logic [2:0] ch_a; // Addressed channel
	logic [2:0] reg_a; // Addressed register
	logic hit; // Mapped address
	logic [31:0] rdata; // Read mux
	logic [31:0] prdata_q; // Held read data

	assign wr_acc = PSEL & PENABLE & PWRITE;
	assign rd_acc = PSEL & PENABLE & ~PWRITE;
	assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
	assign glb = PADDR[`DCS_GLB_BIT];
	assign ch_a = PADDR[7:5];
	assign reg_a = PADDR[4:2];
	assign xdone = state_q == XF_WRITE;

	// Decode; shared space only uses its first slots, so other offsets error
	always_comb begin
		hit = 1'b0;
		if (PADDR[11:9] == 3'h0 && PADDR[1:0] == 2'h0) begin
			if (glb)
				hit = (ch_a == 3'h0) && (reg_a <= `DCS_GREG_IMSK);
			else
				hit = ({1'b0, ch_a} < 4'(NCH)) && (reg_a <= `DCS_REG_CNT);
		end
	end

	// Zero-wait slave: read data is captured in setup, shown in access
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~hit;
	assign PRDATA = prdata_q;

	// Read mux; upper halves and unimplemented fields read zero
	always_comb begin
		rdata = 32'h0000_0000;
		if (hit && glb) begin
			unique case (reg_a)
				`DCS_GREG_COL: rdata[15:0] = {pcol_q, xcol_q};
				`DCS_GREG_IST: rdata[NCH-1:0] = ist_q;
				`DCS_GREG_IMSK: rdata[NCH-1:0] = imsk_q;
				default: rdata = 32'h0000_0000;
			endcase
		end else if (hit) begin
			unique case (reg_a)
				`DCS_REG_CTL: begin
					rdata[`DCS_CTL_EN] = en_q[ch_a];
					rdata[`DCS_CTL_DIR] = dir_q[ch_a];
					rdata[`DCS_CTL_PP] = pp_q[ch_a];
				end
				`DCS_REG_REQ: begin
					rdata[`DCS_REQ_FORCE] = force_q[ch_a];
					rdata[`DCS_SEL_W-1:0] = sel_q[ch_a];
				end
				`DCS_REG_STA: rdata[15:0] = ptr_q[ch_a];
				`DCS_REG_STB: rdata[15:0] = ptr_q[ch_a];
				`DCS_REG_PAD: rdata[15:0] = pad_q[ch_a];
				`DCS_REG_CNT: rdata[`DCS_CNT_W-1:0] = cnt_q[ch_a];
				default: rdata = 32'h0000_0000;
			endcase
		end
	end

	// Read data register
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			prdata_q <= 32'h0000_0000;
		else if (rd_setup)
			prdata_q <= rdata;
	end

	// Fixed priority: lowest channel number wins
	always_comb begin
		gnt = 3'h0;
		gnt_v = 1'b0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (want[i]) begin
				gnt = 3'(i);
				gnt_v = 1'b1;
			end
		end
	end

	// Per-channel registers and pointers
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		logic wsel; // This channel written
		logic cur; // Selected request level
		logic blk_end; // Last transfer of block
		logic mine; // Engine finishing for this channel
		assign wsel = wr_acc && hit && !glb && ch_a == 3'(g);
		assign cur = REQ_LINES[sel_q[g]];
		assign mine = xdone && act_q == 3'(g);
		assign blk_end = rem_q[g] == cnt_q[g];
		assign want[g] = en_q[g] & (force_q[g] | trig_q[g]);

		// Configuration written by software; all zero after reset
		always_ff @(posedge SYS_CLK or negedge RST_N) begin
			if (!RST_N) begin
				en_q[g] <= 1'b0;
				dir_q[g] <= 1'b0;
				pp_q[g] <= 1'b0;
				sel_q[g] <= 7'h00;
				sta_q[g] <= `DCS_RST16;
				stb_q[g] <= `DCS_RST16;
				pad_q[g] <= `DCS_RST16;
				cnt_q[g] <= 10'h000;
			end else if (wsel) begin
				unique case (reg_a)
					`DCS_REG_CTL: begin
						en_q[g] <= PWDATA[`DCS_CTL_EN];
						dir_q[g] <= PWDATA[`DCS_CTL_DIR];
						pp_q[g] <= PWDATA[`DCS_CTL_PP];
					end
					`DCS_REG_REQ: sel_q[g] <= PWDATA[`DCS_SEL_W-1:0];
					`DCS_REG_STA: sta_q[g] <= PWDATA[15:0];
					`DCS_REG_STB: stb_q[g] <= PWDATA[15:0];
					`DCS_REG_PAD: pad_q[g] <= PWDATA[15:0];
					`DCS_REG_CNT: cnt_q[g] <= PWDATA[`DCS_CNT_W-1:0];
					default: ;
				endcase
			end
		end

		// Force bit: software only sets it, the end of the move clears it
		always_ff @(posedge SYS_CLK or negedge RST_N) begin
			if (!RST_N)
				force_q[g] <= 1'b0;
			else if (wsel && reg_a == `DCS_REG_REQ && PWDATA[`DCS_REQ_FORCE])
				force_q[g] <= 1'b1;
			else if (mine && act_force_q)
				force_q[g] <= 1'b0;
		end

		// Request edge catcher; a new edge wins over the grant clear
		always_ff @(posedge SYS_CLK or negedge RST_N) begin
			if (!RST_N) begin
				prev_q[g] <= 1'b0;
				trig_q[g] <= 1'b0;
			end else begin
				prev_q[g] <= cur;
				if (en_q[g] && cur && !prev_q[g])
					trig_q[g] <= 1'b1;
				else if (!en_q[g] || (state_q == XF_IDLE && gnt_v && gnt == 3'(g) && !force_q[g]))
					trig_q[g] <= 1'b0;
			end
		end

		// Working pointer and block count; writes reload the selected buffer
		always_ff @(posedge SYS_CLK or negedge RST_N) begin
			if (!RST_N) begin
				ptr_q[g] <= `DCS_RST16;
				rem_q[g] <= 10'h000;
				bsel_q[g] <= 1'b0;
			end else if (wsel && reg_a == `DCS_REG_CTL && PWDATA[`DCS_CTL_EN] && !en_q[g]) begin
				ptr_q[g] <= sta_q[g];
				rem_q[g] <= 10'h000;
				bsel_q[g] <= 1'b0;
			end else if (wsel && reg_a == `DCS_REG_STA && !bsel_q[g]) begin
				ptr_q[g] <= PWDATA[15:0];
			end else if (wsel && reg_a == `DCS_REG_STB && bsel_q[g]) begin
				ptr_q[g] <= PWDATA[15:0];
			end else if (mine && blk_end) begin
				rem_q[g] <= 10'h000;
				bsel_q[g] <= bsel_q[g] ^ pp_q[g];
				ptr_q[g] <= (bsel_q[g] ^ pp_q[g]) ? stb_q[g] : sta_q[g];
			end else if (mine) begin
				rem_q[g] <= rem_q[g] + 10'h001;
				ptr_q[g] <= ptr_q[g] + `DCS_ADDR_STEP;
			end
		end

		// Collision and block-done flags; detection wins over a clear
		always_ff @(posedge SYS_CLK or negedge RST_N) begin
			if (!RST_N) begin
				xcol_q[g] <= 1'b0;
				pcol_q[g] <= 1'b0;
				ist_q[g] <= 1'b0;
			end else begin
				if (mine && !act_dir_q && CPU_RAM_WE && CPU_RAM_ADDR == ram_addr_q)
					xcol_q[g] <= 1'b1;
				else if (wr_acc && hit && glb && reg_a == `DCS_GREG_COL && !PWDATA[g])
					xcol_q[g] <= 1'b0;
				if (mine && act_dir_q && CPU_PER_WE && CPU_PER_ADDR == per_addr_q)
					pcol_q[g] <= 1'b1;
				else if (wr_acc && hit && glb && reg_a == `DCS_GREG_COL && !PWDATA[g + 8])
					pcol_q[g] <= 1'b0;
				if (mine && blk_end)
					ist_q[g] <= 1'b1;
				else if (rd_acc && hit && glb && reg_a == `DCS_GREG_IST)
					ist_q[g] <= 1'b0;
			end
		end
	end

	// Interrupt mask register
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			imsk_q <= '0;
		else if (wr_acc && hit && glb && reg_a == `DCS_GREG_IMSK)
			imsk_q <= PWDATA[NCH-1:0];
	end

	assign IRQ = |(ist_q & imsk_q);

	// Transfer engine: read source, capture word, write destination
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= XF_IDLE;
			act_q <= 3'h0;
			act_force_q <= 1'b0;
			act_dir_q <= 1'b0;
			ram_addr_q <= `DCS_RST16;
			per_addr_q <= `DCS_RST16;
			data_q <= `DCS_RST16;
		end else begin
			unique case (state_q)
				XF_IDLE: if (gnt_v) begin
					state_q <= XF_READ;
					act_q <= gnt;
					act_force_q <= force_q[gnt];
					act_dir_q <= dir_q[gnt];
					ram_addr_q <= ptr_q[gnt];
					per_addr_q <= pad_q[gnt];
				end
				XF_READ: state_q <= XF_CAPT;
				XF_CAPT: begin
					state_q <= XF_WRITE;
					data_q <= act_dir_q ? RAM_RDATA : PER_RDATA;
				end
				XF_WRITE: state_q <= XF_IDLE;
			endcase
		end
	end

	// Bus strobes follow the state; direction picks the side
	assign RAM_ADDR = ram_addr_q;
	assign PER_ADDR = per_addr_q;
	assign RAM_WDATA = data_q;
	assign PER_WDATA = data_q;
	assign RAM_RE = state_q == XF_READ && act_dir_q;
	assign PER_RE = state_q == XF_READ && !act_dir_q;
	assign RAM_WE = xdone && !act_dir_q;
	assign PER_WE = xdone && act_dir_q;

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	a_force_start: assert property (state_q == XF_IDLE && want == 8'h01 && force_q[0] |=> state_q == XF_READ && act_q == 3'h0 ##2 PER_WE || RAM_WE) else $error("forced move did not start");
	a_req_cause: assert property ($rose(state_q == XF_READ) && act_q == 3'h0 |-> $past(en_q[0]) && ($past(force_q[0]) || $past(trig_q[0]))) else $error("move without request");
	a_force_clear: assert property ($fell(force_q[0]) |-> $past(xdone) && $past(act_q) == 3'h0 && $past(act_force_q)) else $error("force cleared early");
	a_ptr_read: assert property (rd_setup && hit && !glb && ch_a == 3'h1 && reg_a == `DCS_REG_STA |=> PRDATA[15:0] == $past(ptr_q[1])) else $error("start read not pointer");
	a_block_wrap: assert property (xdone && act_q == 3'h0 && rem_q[0] == cnt_q[0] |=> rem_q[0] == 10'h000 && ist_q[0]) else $error("block end missed");
	a_upper_zero: assert property (PSEL && PENABLE |-> PRDATA[31:16] == 16'h0000) else $error("upper bits not zero");
	a_col_detect: assert property (xdone && !act_dir_q && CPU_RAM_WE && CPU_RAM_ADDR == RAM_ADDR |=> xcol_q[$past(act_q)]) else $error("RAM collision lost");
	a_col_source: assert property ($rose(pcol_q[0]) |-> $past(PER_WE) && $past(act_q) == 3'h0) else $error("flag set without collision");
	a_write_order: assert property (PER_WE || RAM_WE |-> $past(state_q, 2) == XF_READ && $past(act_dir_q) == PER_WE) else $error("write out of order");

	c_forced: cover property (xdone && act_force_q);
	c_block: cover property (xdone && rem_q[act_q] == cnt_q[act_q]);
	c_collision: cover property ($rose(xcol_q[0]));
	c_irq: cover property ($rose(IRQ));
endmodule

// ### include/dcs_defs.svh
// Register offsets, field positions and widths of the DMA channel block
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH
`define DCS_NCH 8
`define DCS_NREQ 128
`define DCS_GLB_BIT 8
`define DCS_REG_CTL 3'h0
`define DCS_REG_REQ 3'h1
`define DCS_REG_STA 3'h2
`define DCS_REG_STB 3'h3
`define DCS_REG_PAD 3'h4
`define DCS_REG_CNT 3'h5
`define DCS_GREG_COL 3'h0
`define DCS_GREG_IST 3'h1
`define DCS_GREG_IMSK 3'h2
`define DCS_CTL_EN 15
`define DCS_CTL_DIR 13
`define DCS_CTL_PP 1
`define DCS_REQ_FORCE 15
`define DCS_SEL_W 7
`define DCS_CNT_W 10
`define DCS_ADDR_STEP 16'h0002
`define DCS_RST16 16'h0000
`endif

// ### include/dcs_pkg.sv
// Types shared by the DMA channel block
package dcs_pkg;
	typedef enum logic [1:0] {XF_IDLE, XF_READ, XF_CAPT, XF_WRITE} dcs_xfer_e; // Transfer engine
	typedef logic [15:0] dcs_word_t; // Data and address word
endpackage

// ### test/dcs_periph_model.sv
// Far-side model: DMA RAM and peripheral registers
module dcs_periph_model (
	input wire logic clk, // System clock
	input wire logic rst_n, // Reset, low
	input wire logic [15:0] ram_addr, // RAM address
	input wire logic ram_re, // RAM read strobe
	input wire logic ram_we, // RAM write strobe
	input wire logic [15:0] ram_wdata, // RAM write data
	input wire logic [15:0] per_addr, // Peripheral address
	input wire logic per_re, // Peripheral read strobe
	input wire logic per_we, // Peripheral write strobe
	input wire logic [15:0] per_wdata, // Peripheral write data
	output logic [15:0] ram_rdata, // RAM read data
	output logic [15:0] per_rdata // Peripheral read data
);
	timeunit 1ns;
	timeprecision 1ps;
	int n_wr; // Writes seen on either side
	logic w_per; // Last write hit a peripheral
	logic [15:0] w_addr; // Last write address
	logic [15:0] w_data; // Last write data
	// Data one cycle after the strobe; scrambled otherwise so stale reads show
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ram_rdata <= 16'h0000;
			per_rdata <= 16'h0000;
		end else begin
			ram_rdata <= ram_re ? (ram_addr ^ 16'h5A5A) : ~ram_rdata;
			per_rdata <= per_re ? (per_addr ^ 16'hC3C3) : ~per_rdata;
		end
	end
	// Write log for the bench
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			n_wr <= 0;
		end else if (ram_we | per_we) begin
			n_wr <= n_wr + 1;
			w_per <= per_we;
			w_addr <= per_we ? per_addr : ram_addr;
			w_data <= per_we ? per_wdata : ram_wdata;
		end
	end
endmodule

// ### test/dcs_dma_channels_tb.sv
// Self-checking bench for the DMA channel block
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e); end end
module dcs_dma_channels_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0; // Clock, reset, APB controls
	logic [11:0] paddr = 0; // APB address
	logic [31:0] pwdata = 0, prdata, rd; // APB data, last read
	logic pready, pslverr, irq, err; // Design flags
	logic [127:0] req = '0; // Request lines
	logic cpu_rwe = 0, cpu_pwe = 0; // CPU write strobes
	logic [15:0] cpu_ra = 0, cpu_pa = 0; // CPU write addresses
	logic [15:0] ram_addr, ram_wdata, per_addr, per_wdata, ram_rdata, per_rdata; // Far side
	logic ram_re, ram_we, per_re, per_we; // Far side strobes
	int n_mismatch = 0, comparisons = 0, c, n0; // Counters, channel under test
	logic [31:0] seed = 32'hFA2F347B; // Fixed seed
	logic [15:0] s, s2, p; // Buffer A, buffer B, peripheral address
	logic [6:0] sel; // Request number
	dcs_dma_channels i_dcs_dma_channels (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.REQ_LINES(req), .RAM_ADDR(ram_addr), .RAM_RE(ram_re), .RAM_WE(ram_we), .RAM_WDATA(ram_wdata),
		.RAM_RDATA(ram_rdata), .PER_ADDR(per_addr), .PER_RE(per_re), .PER_WE(per_we), .PER_WDATA(per_wdata),
		.PER_RDATA(per_rdata), .CPU_RAM_WE(cpu_rwe), .CPU_RAM_ADDR(cpu_ra), .CPU_PER_WE(cpu_pwe),
		.CPU_PER_ADDR(cpu_pa), .IRQ(irq));
	dcs_periph_model i_dcs_periph_model (.clk(clk), .rst_n(rst_n), .ram_addr(ram_addr), .ram_re(ram_re),
		.ram_we(ram_we), .ram_wdata(ram_wdata), .per_addr(per_addr), .per_re(per_re), .per_we(per_we),
		.per_wdata(per_wdata), .ram_rdata(ram_rdata), .per_rdata(per_rdata));
	// Xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Word the far-side model hands back for a read at an address
	function automatic logic [15:0] exp_word(input logic from_ram, input logic [15:0] a);
		return from_ram ? (a ^ 16'h5A5A) : (a ^ 16'hC3C3);
	endfunction
	// Byte address of a channel register
	function automatic logic [11:0] ra(int ch, int off);
		return 12'(ch * 32 + off);
	endfunction
	// One APB transfer; holds until ready, then an idle edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e, "read")
	endtask
	// Wait, bounded, for exactly one more far-side write
	task automatic wx();
		n0 = i_dcs_periph_model.n_wr;
		repeat (40) begin
			@(posedge clk);
			if (i_dcs_periph_model.n_wr != n0) break;
		end
		repeat (2) @(posedge clk);
		`CHK(i_dcs_periph_model.n_wr, n0 + 1, "xfer count")
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Free-running clock, 4 ns
	initial begin
		forever #2 clk = ~clk;
	end
	// Hang guard, far beyond the expected run
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		final_report();
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		c = int'(rnd() % 8);
		sel = 7'(rnd());
		s = 16'(rnd()) & 16'hFFFE;
		s2 = 16'(rnd()) & 16'hFFFE;
		p = 16'(rnd());
		cpu_ra <= 16'(rnd());
		for (int ch = 0; ch < 8; ch++) for (int o = 4; o <= 20; o += 4) rchk(ra(ch, o), 0);
		rchk(12'h100, 0);
		rchk(ra(c, 24), 0);
		`CHK(err, 1'b1, "unmapped")
		$display("test reset done");
		for (int ch = 0; ch < 8; ch++) wr(ra(ch, 16), 32'(ch * 16'h1357 + 1));
		for (int ch = 0; ch < 8; ch++) rchk(ra(ch, 16), 32'(ch * 16'h1357 + 1));
		wr(ra(c, 4), 32'h7F80 | 32'(sel));
		rchk(ra(c, 4), 32'(sel));
		wr(ra(c, 20), 32'hFFFFFC01);
		rchk(ra(c, 20), 32'h1);
		$display("test fields done");
		// Force on a disabled channel stays pending, zero write ignored
		wr(ra(c, 4), 32'h8000 | 32'(sel));
		wr(ra(c, 4), 32'(sel));
		rchk(ra(c, 4), 32'h8000 | 32'(sel));
		`CHK(i_dcs_periph_model.n_wr, 0, "disabled moved")
		// Config written only while disabled
		wr(ra(c, 8), 32'(s));
		wr(ra(c, 12), 32'(s2));
		wr(ra(c, 16), 32'(p));
		wr(ra(c, 0), 32'h8000);
		wx();
		`CHK(i_dcs_periph_model.w_addr, s, "force addr")
		`CHK(i_dcs_periph_model.w_data, exp_word(1'b0, p), "force data")
		rchk(ra(c, 4), 32'(sel));
		rchk(ra(c, 8), 32'(s + 16'h2));
		rchk(ra(c, 12), 32'(s + 16'h2));
		$display("test force done");
		// Unselected lines toggle; nothing moves
		req <= {rnd(), rnd(), rnd(), rnd()} & ~(128'h1 << sel);
		repeat (20) @(posedge clk);
		`CHK(i_dcs_periph_model.n_wr, 1, "unselected")
		req <= req | (128'h1 << sel);
		cpu_rwe <= 1'b1;
		cpu_ra <= s + 16'h2;
		wx();
		`CHK(i_dcs_periph_model.w_addr, s + 16'h2, "req addr")
		cpu_rwe <= 1'b0;
		req <= '0;
		rchk(ra(c, 8), 32'(s));
		rchk(12'h100, 32'h1 << c);
		wr(12'h100, 32'hFFFF);
		rchk(12'h100, 32'h1 << c);
		wr(12'h100, 32'h0);
		rchk(12'h100, 32'h0);
		$display("test request done");
		// RAM to peripheral with a clashing CPU write
		wr(ra(c, 0), 32'hA000);
		cpu_pwe <= 1'b1;
		cpu_pa <= p;
		wr(ra(c, 4), 32'h8000 | 32'(sel));
		wx();
		cpu_pwe <= 1'b0;
		`CHK(i_dcs_periph_model.w_per, 1'b1, "dir")
		`CHK(i_dcs_periph_model.w_addr, p, "per addr")
		`CHK(i_dcs_periph_model.w_data, exp_word(1'b1, s), "per data")
		rchk(12'h100, 32'h100 << c);
		wr(12'h100, 32'h0);
		$display("test direction done");
		// Ping-pong, one-transfer blocks, masked then unmasked interrupt
		wr(ra(c, 0), 32'h0);
		wr(ra(c, 20), 32'h0);
		wr(ra(c, 0), 32'h8002);
		apb(1'b0, 12'h104, 32'h0);
		wr(ra(c, 4), 32'h8000 | 32'(sel));
		wx();
		`CHK(i_dcs_periph_model.w_addr, s, "buf a")
		`CHK(irq, 1'b0, "masked")
		rchk(12'h104, 32'h1 << c);
		wr(12'h108, 32'h1 << c);
		wr(ra(c, 4), 32'h8000 | 32'(sel));
		wx();
		`CHK(i_dcs_periph_model.w_addr, s2, "buf b")
		`CHK(irq, 1'b1, "irq")
		apb(1'b0, 12'h104, 32'h0);
		`CHK(irq, 1'b0, "irq clear")
		$display("test block done");
		// Channel 0 forced RAM to peripheral move, one-transfer block, clashing CPU write
		wr(ra(c, 0), 32'h0);
		wr(ra(0, 8), 32'(s2));
		wr(ra(0, 16), 32'h1);
		wr(ra(0, 20), 32'h0);
		wr(ra(0, 0), 32'hA000);
		cpu_pwe <= 1'b1;
		cpu_pa <= 16'h0001;
		wr(ra(0, 4), 32'h8000);
		wx();
		cpu_pwe <= 1'b0;
		`CHK(i_dcs_periph_model.w_addr, 16'h0001, "ch0 per addr")
		`CHK(i_dcs_periph_model.w_data, exp_word(1'b1, s2), "ch0 data")
		rchk(12'h100, 32'h100);
		rchk(12'h104, 32'h1);
		rchk(ra(0, 8), 32'(s2));
		rchk(ra(0, 4), 32'h0);
		$display("test channel zero done");
		final_report();
	end
endmodule
